//--- rtl/sfps_defs.svh
`ifndef SFPS_DEFS_SVH
`define SFPS_DEFS_SVH

// Command opcodes
`define SFPS_OPC_PAGE_PROG 8'h02
`define SFPS_OPC_QUAD_PROG 8'h38
`define SFPS_OPC_SLEEP 8'hB9
`define SFPS_OPC_WAKE_SIG 8'hAB
`define SFPS_OPC_MAKER_ID 8'h90
`define SFPS_ID_SWAP_ADDR 8'h01

// Bit positions within a frame
`define SFPS_POS_OPC 6'h08
`define SFPS_POS_A2 6'h10
`define SFPS_POS_A1 6'h18
`define SFPS_POS_DATA 6'h20
`define SFPS_STEP_SER 3'h1
`define SFPS_STEP_QUAD 3'h4
`define SFPS_SO_LANE 1

// Page layout
`define SFPS_PAGE_BYTES 256
`define SFPS_DCNT_FULL 9'h100
`define SFPS_NBLK 64

// Timing, ns; reference clock period
`define SFPS_CLK_NS 4
`define SFPS_PROG_NS 1400000
`define SFPS_SLEEP_NS 10000
`define SFPS_WAKE_NS 30000

// Identity bytes, values arbitrary
`define SFPS_SIG_DEF 8'h5A
`define SFPS_MFR_DEF 8'h3C
`define SFPS_DEV_DEF 8'h5A

`endif

//--- rtl/sfps_pkg.sv
package sfps_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PROG = 4'h2,
    ST_SLEEP_WAIT = 4'h4,
    ST_WAKE_WAIT = 4'h8
  } sfps_state_type;

endpackage

//--- rtl/sfps_flash_seq.sv
// Functional notes
// [R1] Page program accepted only while write_unlock_latch is set.
// [R2] Over 256 data bytes: only the final 256 bytes are programmed.
// [R3] Data past the page end wraps to the page start.
// [R4] Up to 256 bytes program from the address; other page bytes untouched.
// [R5] Host sends opcode 02, 3 address bytes, at least one data byte.
// [R6] Chip select must rise right after a data byte, else reject.
// [R7] Chip select rise starts timed program; busy held; both flags cleared after.
// [R8] A program into a page protected by block_protect_bits is refused.
// [R9] Command takes 8 serial or 2 quad clocks; upper lines ignored serially.
// [R10] Quad program needs latch and quad_io_enable; address and data on four lines.
// [R11] Quad program behaves as page program, only four lines wide.
// [R12] Host should keep serial clock below 33MHz for quad program data.
// [R13] Opcode B9 enters deep sleep; writes and programs then ignored.
// [R14] Asleep, only wake, signature read and software reset are honoured.
// [R15] Sleep needs rise right after opcode, entered after sleep_entry_delay.
// [R16] Software reset or power cycle ends deep sleep; power-up gives standby.
// [R17] Wake: standby at once if awake, else after wake_delay.
// [R18] Wake and signature read ignored during a program; cycle undisturbed.
// [R19] Opcode AB returns signature byte, repeated while clocks continue.
// [R20] Opcode 90h, two dummies, address byte, then maker and part codes.
// [R21] Address 01h gives part code first; codes alternate while selected.
// [R22] A refused program leaves array and busy_flag unchanged.
`timescale 1ns/10ps
`include "sfps_defs.svh"

module sfps_flash_seq import sfps_pkg::*; #(
  parameter int PROG_TIME_NS = `SFPS_PROG_NS,
  parameter int SLEEP_TIME_NS = `SFPS_SLEEP_NS,
  parameter int WAKE_TIME_NS = `SFPS_WAKE_NS,
  parameter int NUM_BLOCKS = `SFPS_NBLK,
  parameter logic [7:0] QUAD_PROG_OPC = `SFPS_OPC_QUAD_PROG,
  parameter logic [7:0] SIG_CODE = `SFPS_SIG_DEF, // Value arbitrary
  parameter logic [7:0] MFR_CODE = `SFPS_MFR_DEF, // Value arbitrary
  parameter logic [7:0] DEV_CODE = `SFPS_DEV_DEF  // Value arbitrary
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic [3:0] sio_i,
  output logic [3:0] sio_o,
  output logic [3:0] sio_oe_o,
  input wire logic qpi_mode_i,
  input wire logic quad_io_enable_i,
  input wire logic [3:0] block_protect_bits_i,
  input wire logic write_unlock_set_i,
  input wire logic sw_reset_i,
  output logic write_unlock_latch_o,
  output logic busy_flag_o,
  output logic deep_sleep_o,
  output logic prog_we_o,
  output logic [23:0] prog_addr_o,
  output logic [7:0] prog_data_o,
  output logic cmd_reject_o
);

  localparam int PROG_CYC = (PROG_TIME_NS + `SFPS_CLK_NS - 1) / `SFPS_CLK_NS;
  localparam int SLEEP_CYC = (SLEEP_TIME_NS + `SFPS_CLK_NS - 1) / `SFPS_CLK_NS;
  localparam int WAKE_CYC = (WAKE_TIME_NS + `SFPS_CLK_NS - 1) / `SFPS_CLK_NS;

  // The page sweep runs inside the program time, so it must be longer
  if (PROG_CYC <= `SFPS_PAGE_BYTES || SLEEP_CYC < 1 || WAKE_CYC < 1) begin : g_bad_time
    $error("sfps_flash_seq: timing parameters too small");
  end
  if (NUM_BLOCKS < 1 || NUM_BLOCKS > 256) begin : g_bad_blocks
    $error("sfps_flash_seq: NUM_BLOCKS out of range");
  end

  // ---------------- Link side, on the serial clock ----------------
  logic lk_rstn;
  logic frame_open_r;
  logic [5:0] pos_r;
  logic [2:0] bitc_r;
  logic [8:0] dcnt_r;
  logic [7:0] sh_r;
  logic [7:0] opc_r;
  logic [23:0] addr_r;
  logic [255:0] mask_r;
  logic [7:0] pb_mem [0:255];
  logic rd_on_r;
  logic rd_maker_r;
  logic swap_r;
  logic [3:0] ocnt_r;
  logic so_r;
  logic oe_r;
  logic lk_busy_s1_r, lk_busy_s2_r;
  logic lk_sleep_s1_r, lk_sleep_s2_r;
  logic lk_qpi_s1_r, lk_qpi_s2_r;

  // Chip select high clears the frame; the sampled command stays for the other side
  assign lk_rstn = rstn_i & ~cs_n_i;

  // Framing state as seen at this edge
  wire [5:0] pos_cur = frame_open_r ? pos_r : 6'h00;
  wire [2:0] bitc_cur = frame_open_r ? bitc_r : 3'h0;
  wire [8:0] dcnt_cur = frame_open_r ? dcnt_r : 9'h000;
  wire rd_cur = frame_open_r & rd_on_r;
  wire in_hdr = pos_cur < `SFPS_POS_DATA;
  wire is_prog_lk = (opc_r == `SFPS_OPC_PAGE_PROG) || (opc_r == QUAD_PROG_OPC);
  // Serial mode reads only the low line, quad reads all four
  wire quad_now = lk_qpi_s2_r | ((pos_cur >= `SFPS_POS_OPC) && (opc_r == QUAD_PROG_OPC)); // [R9] [R11]
  wire [2:0] step = quad_now ? `SFPS_STEP_QUAD : `SFPS_STEP_SER;
  wire [7:0] sh_nxt = quad_now ? {sh_r[3:0], sio_i} : {sh_r[6:0], sio_i[0]}; // [R9] [R10]
  wire [5:0] pos_nxt = in_hdr ? pos_cur + 6'(step) : pos_cur;
  wire [2:0] bitc_nxt = in_hdr ? 3'h0 : bitc_cur + step;
  wire byte_done = in_hdr ? (pos_nxt[2:0] == 3'h0) : (bitc_nxt == 3'h0);
  wire opc_done = byte_done && (pos_nxt == `SFPS_POS_OPC);
  wire data_done = byte_done && !in_hdr;
  wire collect = data_done && is_prog_lk && !lk_busy_s2_r;
  // Index wraps inside the page; later bytes overwrite earlier ones
  wire [7:0] wr_idx = addr_r[7:0] + dcnt_cur[7:0]; // [R2] [R3]
  wire sig_start = opc_done && (sh_nxt == `SFPS_OPC_WAKE_SIG) && !lk_qpi_s2_r
                   && !lk_busy_s2_r; // [R18] [R19]
  wire id_start = byte_done && in_hdr && (pos_nxt == `SFPS_POS_DATA)
                  && (opc_r == `SFPS_OPC_MAKER_ID) && !lk_qpi_s2_r
                  && !lk_busy_s2_r && !lk_sleep_s2_r; // [R14] [R20]

  // Frame-open flag, cleared asynchronously by chip select
  always_ff @(posedge sck_i or negedge lk_rstn) begin
    if (!lk_rstn) begin
      frame_open_r <= 1'b0;
    end else begin
      frame_open_r <= 1'b1;
    end
  end

  // Level crossings into the link domain
  always_ff @(posedge sck_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lk_busy_s1_r <= 1'b0;
      lk_busy_s2_r <= 1'b0;
      lk_sleep_s1_r <= 1'b0;
      lk_sleep_s2_r <= 1'b0;
      lk_qpi_s1_r <= 1'b0;
      lk_qpi_s2_r <= 1'b0;
    end else begin
      lk_busy_s1_r <= busy_flag_o;
      lk_busy_s2_r <= lk_busy_s1_r;
      lk_sleep_s1_r <= deep_sleep_o;
      lk_sleep_s2_r <= lk_sleep_s1_r;
      lk_qpi_s1_r <= qpi_mode_i;
      lk_qpi_s2_r <= lk_qpi_s1_r;
    end
  end

  // Bit and byte counters; held after the frame for the commit check
  always_ff @(posedge sck_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pos_r <= 6'h00;
      bitc_r <= 3'h0;
      sh_r <= 8'h00;
    end else begin
      pos_r <= pos_nxt;
      bitc_r <= bitc_nxt;
      sh_r <= sh_nxt;
    end
  end

  // Opcode, address and data byte count capture
  always_ff @(posedge sck_i or negedge rstn_i) begin
    if (!rstn_i) begin
      opc_r <= 8'h00;
      addr_r <= 24'h000000;
      dcnt_r <= 9'h000;
    end else begin
      if (opc_done) opc_r <= sh_nxt;
      if (byte_done && pos_nxt == `SFPS_POS_A2) addr_r[23:16] <= sh_nxt;
      if (byte_done && pos_nxt == `SFPS_POS_A1) addr_r[15:8] <= sh_nxt;
      if (byte_done && in_hdr && pos_nxt == `SFPS_POS_DATA) addr_r[7:0] <= sh_nxt;
      if (collect && dcnt_cur >= `SFPS_DCNT_FULL) begin
        // Past a full page the low byte keeps counting, so later bytes keep wrapping
        dcnt_r <= {1'b1, dcnt_cur[7:0] + 8'h01}; // [R2]
      end else if (collect) begin
        dcnt_r <= dcnt_cur + 9'h001;
      end else begin
        dcnt_r <= dcnt_cur;
      end
    end
  end

  // Byte-valid mask; only bytes received are programmed, the rest untouched
  always_ff @(posedge sck_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_r <= '0;
    end else if (opc_done && !lk_busy_s2_r) begin
      mask_r <= '0; // [R4]
    end else if (collect) begin
      mask_r[wr_idx] <= 1'b1; // [R4]
    end
  end

  // Page buffer; frozen while a program cycle reads it
  always_ff @(posedge sck_i) begin
    if (collect) pb_mem[wr_idx] <= sh_nxt; // [R2] [R3]
  end

  // Read-out bit counter
  always_ff @(posedge sck_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_on_r <= 1'b0;
      rd_maker_r <= 1'b0;
      swap_r <= 1'b0;
      ocnt_r <= 4'h0;
    end else if (sig_start || id_start) begin
      rd_on_r <= 1'b1;
      rd_maker_r <= id_start;
      swap_r <= (sh_nxt == `SFPS_ID_SWAP_ADDR); // [R21]
      ocnt_r <= 4'h0;
    end else begin
      rd_on_r <= rd_cur;
      ocnt_r <= ocnt_r + 4'h1; // [R19] [R21]
    end
  end

  // Maker read alternates the two codes; signature read repeats one byte
  wire [7:0] id_byte = (ocnt_r[3] ^ swap_r) ? DEV_CODE : MFR_CODE; // [R21]
  wire [7:0] out_byte = rd_maker_r ? id_byte : SIG_CODE;

  // Output shifts on the falling edge, MSB first
  always_ff @(negedge sck_i or negedge lk_rstn) begin
    if (!lk_rstn) begin
      so_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      so_r <= out_byte[~ocnt_r[2:0]]; // [R20]
      oe_r <= rd_on_r;
    end
  end

  // Only the serial output line is ever driven
  assign sio_o = 4'(so_r) << `SFPS_SO_LANE;
  assign sio_oe_o = 4'(oe_r) << `SFPS_SO_LANE;

  // ---------------- Core side, on the reference clock ----------------
  sfps_state_type st_r, st_nxt;
  logic cs_s1_r, cs_s2_r, cs_d_r;
  logic [31:0] tmr_r, tmr_nxt;
  logic [8:0] idx_r, idx_nxt;
  logic sleep_r, sleep_nxt;
  logic wel_r, wel_nxt;
  logic rej_nxt;

  // Link fields are stable once the frame ends, since the clock has stopped
  wire cs_rise = cs_s2_r & ~cs_d_r;
  wire is_pp = (opc_r == `SFPS_OPC_PAGE_PROG) && (pos_r >= `SFPS_POS_OPC);
  wire is_qpp = (opc_r == QUAD_PROG_OPC) && (pos_r >= `SFPS_POS_OPC);
  wire is_sleep = (opc_r == `SFPS_OPC_SLEEP) && (pos_r >= `SFPS_POS_OPC);
  wire is_wake = (opc_r == `SFPS_OPC_WAKE_SIG) && (pos_r >= `SFPS_POS_OPC);
  wire bound_ok = (pos_r == `SFPS_POS_DATA) && (bitc_r == 3'h0)
                  && (dcnt_r != 9'h000); // [R5] [R6]
  wire sleep_ok = (pos_r == `SFPS_POS_OPC); // [R15]

  // Protected span: the top 2^(bits-1) blocks, the whole array at the top codes
  wire [16:0] prot_span = (block_protect_bits_i == 4'h0) ? 17'h00000
                          : 17'h00001 << (block_protect_bits_i - 4'h1);
  wire page_prot = ({9'h000, addr_r[23:16]} + prot_span)
                   >= 17'(NUM_BLOCKS) && (prot_span != 17'h00000); // [R8]
  wire prog_ok = wel_r && bound_ok && !page_prot
                 && (is_pp || quad_io_enable_i); // [R1] [R6] [R8] [R10]

  // Chip-select synchroniser; the rise is taken from the second stage and its delayed copy
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
    end else begin
      cs_s1_r <= cs_n_i;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
    end
  end

  // Sequencer: commit on chip-select rise, then timed cycles
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    idx_nxt = idx_r;
    sleep_nxt = sleep_r;
    wel_nxt = wel_r;
    rej_nxt = 1'b0;
    if (write_unlock_set_i && st_r == ST_IDLE && !sleep_r) wel_nxt = 1'b1;
    case (st_r)
      ST_IDLE: begin
        if (cs_rise) begin
          if (sleep_r) begin
            if (is_wake) begin // [R14] [R17]
              st_nxt = ST_WAKE_WAIT;
              tmr_nxt = 32'(WAKE_CYC - 1);
            end
          end else if (is_pp || is_qpp) begin
            if (prog_ok) begin // [R7] [R11]
              st_nxt = ST_PROG;
              tmr_nxt = 32'(PROG_CYC - 1);
              idx_nxt = 9'h000;
            end else begin
              rej_nxt = 1'b1; // [R22]
            end
          end else if (is_sleep && sleep_ok) begin // [R13] [R15]
            st_nxt = ST_SLEEP_WAIT;
            tmr_nxt = 32'(SLEEP_CYC - 1);
          end
        end
      end
      ST_PROG: begin
        // Commands arriving now, wake included, are dropped
        idx_nxt = idx_r[8] ? idx_r : idx_r + 9'h001; // [R18]
        if (tmr_r == 32'h0) begin
          st_nxt = ST_IDLE;
          wel_nxt = 1'b0; // [R7]
        end else begin
          tmr_nxt = tmr_r - 32'h1;
        end
      end
      ST_SLEEP_WAIT: begin
        if (cs_rise && is_wake) begin
          st_nxt = ST_IDLE; // [R17]
        end else if (tmr_r == 32'h0) begin
          st_nxt = ST_IDLE;
          sleep_nxt = 1'b1; // [R15]
        end else begin
          tmr_nxt = tmr_r - 32'h1;
        end
      end
      ST_WAKE_WAIT: begin
        if (tmr_r == 32'h0) begin
          st_nxt = ST_IDLE;
          sleep_nxt = 1'b0; // [R17]
        end else begin
          tmr_nxt = tmr_r - 32'h1;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    // Software reset ends sleep but never cuts a program short
    if (sw_reset_i && st_r != ST_PROG) begin
      st_nxt = ST_IDLE; // [R16]
      sleep_nxt = 1'b0; // [R16]
    end
  end

  // Sequencer registers; reset comes up awake in standby
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= ST_IDLE;
      tmr_r <= 32'h0;
      idx_r <= 9'h000;
      sleep_r <= 1'b0; // [R16]
      wel_r <= 1'b0;
      cmd_reject_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      idx_r <= idx_nxt;
      sleep_r <= sleep_nxt;
      wel_r <= wel_nxt;
      cmd_reject_o <= rej_nxt;
    end
  end

  // Array write sweep; unreceived bytes get no strobe
  wire sweep_we = (st_r == ST_PROG) && !idx_r[8] && mask_r[idx_r[7:0]]; // [R4]

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prog_we_o <= 1'b0;
      prog_addr_o <= 24'h000000;
      prog_data_o <= 8'h00;
    end else begin
      prog_we_o <= sweep_we;
      prog_addr_o <= {addr_r[23:8], idx_r[7:0]}; // [R3]
      prog_data_o <= pb_mem[idx_r[7:0]];
    end
  end

  assign busy_flag_o = (st_r == ST_PROG); // [R7]
  assign write_unlock_latch_o = wel_r;
  assign deep_sleep_o = sleep_r;

endmodule

//--- tb/sfps_flash_seq_props.sv
`timescale 1ns/10ps
module sfps_flash_seq_props #(
  parameter int PROG_TIME_NS = 2000
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic [3:0] sio_oe_o,
  input wire logic write_unlock_latch_o,
  input wire logic busy_flag_o,
  input wire logic deep_sleep_o,
  input wire logic prog_we_o,
  input wire logic [23:0] prog_addr_o,
  input wire logic cmd_reject_o
);
  localparam int PROG_CYC = PROG_TIME_NS / 4;
  logic [19:0] busy_cnt_r;
  logic [15:0] page_r;
  // Busy length counted here; far too long for a repetition
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_cnt_r <= 20'h00000;
      page_r <= 16'h0000;
    end else begin
      busy_cnt_r <= busy_flag_o ? busy_cnt_r + 20'h00001 : 20'h00000;
      page_r <= prog_addr_o[23:8];
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_cycle_begin;
    $rose(busy_flag_o);
  endsequence
  // Sweep runs in page order, so the first strobe waits for the lowest received offset
  sequence s_first_strobe;
    ##[1:256] prog_we_o;
  endsequence
  a_busy_len: assert property ($fell(busy_flag_o) |->
    busy_cnt_r >= PROG_CYC - 4 && busy_cnt_r <= PROG_CYC + 4) else $error("busy length off");
  a_prog_latch: assert property (s_cycle_begin |-> write_unlock_latch_o)
    else $error("program without latch");
  a_first_strobe: assert property (s_cycle_begin |-> s_first_strobe)
    else $error("no array strobe after start");
  a_strobe_busy: assert property (prog_we_o |-> busy_flag_o)
    else $error("strobe outside program cycle");
  a_strobe_page: assert property (prog_we_o && $past(prog_we_o) |->
    prog_addr_o[23:8] == page_r) else $error("strobe left the page");
  a_reject_idle: assert property (cmd_reject_o && !busy_flag_o |=> !busy_flag_o [*4])
    else $error("refused command started a cycle");
  a_sleep_noprog: assert property (deep_sleep_o && !busy_flag_o |=> !busy_flag_o)
    else $error("program while asleep");
  a_oe_deselect: assert property (cs_n_i |-> sio_oe_o == 4'h0)
    else $error("driving while deselected");
  a_oe_busy: assert property (busy_flag_o |-> sio_oe_o == 4'h0)
    else $error("read answered during program");
  a_oe_lane: assert property (sio_oe_o[3:2] == 2'h0 && !sio_oe_o[0])
    else $error("wrong output lane");
endmodule

bind sfps_flash_seq sfps_flash_seq_props #(.PROG_TIME_NS(PROG_TIME_NS)) u_props (
  .ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i),
  .cs_n_i(cs_n_i),
  .sio_oe_o(sio_oe_o),
  .write_unlock_latch_o(write_unlock_latch_o),
  .busy_flag_o(busy_flag_o),
  .deep_sleep_o(deep_sleep_o),
  .prog_we_o(prog_we_o),
  .prog_addr_o(prog_addr_o),
  .cmd_reject_o(cmd_reject_o)
);

//--- tb/sfps_host_model.sv
`timescale 1ns/10ps
module sfps_host_model (
  output logic sck_o,
  output logic cs_n_o,
  output logic [3:0] sio_o,
  input wire logic [3:0] sio_i
);
  // Clock parks low outside frames; 64 ns bit time stays under 33 MHz
  initial begin
    sck_o = 1'h0;
    cs_n_o = 1'h1;
    sio_o = 4'h0;
  end
  // Offset of 7 after a tick's 1 puts link edges on core rising edges
  task automatic start();
    #7 cs_n_o = 1'h0;
    #32;
  endtask
  // Serial shifts put junk on the unused upper lines
  task automatic put(input logic [7:0] b, input int nb, input bit q);
    int i;
    for (i = 0; i < nb; i++) begin
      sio_o = q ? (i[0] ? b[3:0] : b[7:4]) : {4{b[7 - i]}} ^ 4'hE;
      #32 sck_o = 1'h1;
      #32 sck_o = 1'h0;
    end
  endtask
  // Device shifts on falling clock, so sample on rising
  task automatic get(output logic [7:0] b);
    int i;
    b = 8'h00;
    for (i = 0; i < 8; i++) begin
      #32 sck_o = 1'h1;
      b = {b[6:0], sio_i[1]};
      #32 sck_o = 1'h0;
    end
  endtask
  // Scramble released lines and stay deselected past the wake time
  task automatic stop();
    #32 cs_n_o = 1'h1;
    sio_o = ~sio_o;
    #200;
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  localparam logic [7:0] SIG = 8'h6E; // Arbitrary identity value
  localparam logic [7:0] MFR = 8'h3C; // Arbitrary identity value
  localparam logic [7:0] DEV = 8'h71; // Arbitrary identity value
  localparam logic [7:0] QOPC = 8'h38;
  logic ref_clk_i, rstn_i, sck, cs_n, qpi, qen, wset, swr, write_unlock_latch, busy, slp, we, rej;
  logic [3:0] h_sio, d_sio, d_oe, bp;
  logic [23:0] wa;
  logic [7:0] wd;
  logic [7:0] mem [logic [23:0]];
  int n_fail, cmp_count, n_we, n_rej;
  // Undriven lines read back inverted, so a late or missing enable shows as bad data
  sfps_host_model h (.sck_o(sck), .cs_n_o(cs_n), .sio_o(h_sio), .sio_i(d_sio ^ ~d_oe));
  sfps_flash_seq #(.PROG_TIME_NS(2000), .SLEEP_TIME_NS(100), .WAKE_TIME_NS(100),
    .QUAD_PROG_OPC(QOPC), .SIG_CODE(SIG), .MFR_CODE(MFR), .DEV_CODE(DEV)) dut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .sck_i(sck), .cs_n_i(cs_n), .sio_i(h_sio),
    .sio_o(d_sio), .sio_oe_o(d_oe), .qpi_mode_i(qpi), .quad_io_enable_i(qen),
    .block_protect_bits_i(bp), .write_unlock_set_i(wset), .sw_reset_i(swr),
    .write_unlock_latch_o(write_unlock_latch), .busy_flag_o(busy), .deep_sleep_o(slp), .prog_we_o(we),
    .prog_addr_o(wa), .prog_data_o(wd), .cmd_reject_o(rej));
  // Core clock
  initial begin
    ref_clk_i = 1'h0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // Record array writes and refusals as the block reports them
  always @(posedge ref_clk_i) begin
    if (we === 1'h1) begin
      mem[wa] = wd;
      n_we++;
    end
    if (rej === 1'h1) n_rej++;
  end
  task automatic chk_v(input string nm, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask
  function automatic logic [7:0] dat(input int n);
    return 8'(n * 3 + n / 256);
  endfunction
  task automatic unlock();
    tick();
    wset = 1'h1;
    tick();
    wset = 1'h0;
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 1000 && busy !== 1'h0; k++) tick();
    chk_v("idle", 24'h0, 24'(busy));
  endtask
  // The link sees a mode change only on its own clock; two idle bits carry it across
  task automatic resync();
    h.start();
    h.put(8'h00, 2, 1'h0);
    h.stop();
  endtask
  // Whole program frame; xb adds a trailing partial byte
  task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n, input bit q,
                      input int xb);
    int i;
    mem.delete();
    n_we = 0;
    n_rej = 0;
    h.start();
    h.put(op, qpi ? 2 : 8, qpi);
    for (i = 0; i < 3; i++) h.put(a[23 - 8 * i -: 8], q ? 2 : 8, q);
    for (i = 0; i < n; i++) h.put(dat(i), q ? 2 : 8, q);
    if (xb > 0) h.put(8'hFF, xb, 1'h0);
    h.stop();
  endtask
  task automatic t_reject();
    int c;
    for (c = 0; c < 4; c++) begin
      if (c > 0) unlock();
      bp = (c == 2) ? 4'h1 : 4'h0;
      prog(8'h02, (c == 2) ? 24'h3F0000 : 24'h000040, (c == 3) ? 0 : 1, 1'h0, (c == 1) ? 4 : 0);
      wait_idle();
      chk_v("rej", 24'h1, 24'(n_rej));
      chk_v("writes", 24'h0, 24'(n_we));
    end
    bp = 4'h0;
    $display("Done refusals");
  endtask
  task automatic t_basic();
    logic [7:0] b;
    unlock();
    chk_v("latch", 24'h1, 24'(write_unlock_latch));
    prog(8'h02, 24'h0012FE, 3, 1'h0, 0);
    chk_v("busy", 24'h1, 24'(busy));
    h.start();
    h.put(8'hAB, 8, 1'h0);
    h.get(b);
    h.stop();
    chk_v("busy_read", 24'h1, 24'(busy));
    wait_idle();
    chk_v("latch_end", 24'h0, 24'(write_unlock_latch));
    chk_v("writes", 24'h3, 24'(n_we));
    chk_v("byte0", 24'(dat(0)), 24'(mem[24'h0012FE]));
    chk_v("byte2", 24'(dat(2)), 24'(mem[24'h001200]));
    $display("Done basic program");
  endtask
  task automatic t_over();
    unlock();
    prog(8'h02, 24'h000500, 258, 1'h0, 0);
    wait_idle();
    chk_v("writes", 24'h100, 24'(n_we));
    chk_v("byte256", 24'(dat(256)), 24'(mem[24'h000500]));
    chk_v("byte257", 24'(dat(257)), 24'(mem[24'h000501]));
    chk_v("byte2", 24'(dat(2)), 24'(mem[24'h000502]));
    $display("Done overlong program");
  endtask
  task automatic t_quad();
    qen = 1'h0;
    unlock();
    prog(QOPC, 24'h002010, 2, 1'h1, 0);
    wait_idle();
    chk_v("q_rej", 24'h1, 24'(n_rej));
    qen = 1'h1;
    prog(QOPC, 24'h002010, 2, 1'h1, 0);
    wait_idle();
    chk_v("q_b0", 24'(dat(0)), 24'(mem[24'h002010]));
    chk_v("q_b1", 24'(dat(1)), 24'(mem[24'h002011]));
    qpi = 1'h1;
    unlock();
    resync();
    prog(8'h02, 24'h003000, 1, 1'h1, 0);
    wait_idle();
    chk_v("qpi_b0", 24'(dat(0)), 24'(mem[24'h003000]));
    qpi = 1'h0;
    resync();
    $display("Done quad");
  endtask
  task automatic t_reads();
    logic [7:0] b;
    int s, i;
    h.start();
    h.put(8'hAB, 8, 1'h0);
    for (i = 0; i < 2; i++) begin
      h.get(b);
      chk_v("sig", 24'(SIG), 24'(b));
    end
    h.stop();
    for (s = 0; s < 2; s++) begin
      h.start();
      h.put(8'h90, 8, 1'h0);
      h.put(8'h00, 8, 1'h0);
      h.put(8'h00, 8, 1'h0);
      h.put(8'(s), 8, 1'h0);
      for (i = 0; i < 3; i++) begin
        h.get(b);
        chk_v("id", 24'(((s + i) % 2 == 0) ? MFR : DEV), 24'(b));
      end
      h.stop();
    end
    $display("Done reads");
  endtask
  task automatic sleep_frame(input int nb, input logic e);
    h.start();
    h.put(8'hB9, 8, 1'h0);
    if (nb > 8) h.put(8'h00, 1, 1'h0);
    h.stop();
    repeat (40) tick();
    chk_v("sleep", 24'(e), 24'(slp));
  endtask
  task automatic t_sleep();
    sleep_frame(8, 1'h1);
    unlock();
    chk_v("latch_asleep", 24'h0, 24'(write_unlock_latch));
    prog(8'h02, 24'h000100, 1, 1'h0, 0);
    wait_idle();
    chk_v("writes_asleep", 24'h0, 24'(n_we));
    h.start();
    h.put(8'hAB, 8, 1'h0);
    h.stop();
    repeat (20) tick();
    chk_v("woken", 24'h0, 24'(slp));
    sleep_frame(9, 1'h0);
    sleep_frame(8, 1'h1);
    swr = 1'h1;
    tick();
    swr = 1'h0;
    tick();
    chk_v("sw_reset", 24'h0, 24'(slp));
    $display("Done sleep");
  endtask
  initial begin
    rstn_i = 1'h0;
    qpi = 1'h0;
    qen = 1'h0;
    bp = 4'h0;
    wset = 1'h0;
    swr = 1'h0;
    repeat (12) @(posedge ref_clk_i);
    #1 rstn_i = 1'h1;
    repeat (4) tick();
    t_reject();
    t_basic();
    t_over();
    t_quad();
    t_reads();
    t_sleep();
    tally_and_finish();
  end
  // Tests need about 180 us; a run still going at 300 us has hung
  initial begin
    #300000;
    n_fail++;
    tally_and_finish();
  end
endmodule
